// ### inc/dlk_cfg.svh
// ============================================================
// debug link control/status bank: offsets, fields, resets, timing
// ============================================================
// included by the design file of the debug link register bank
// What this block does
// - read-only 4-bit revision in bits 7:4 of the first status register
// - error signature loads on a link error, clears when the debugger reads it
// - codes: 0 none, 1 parity, 2 stop-bit frame, 3 time-out, 4 clock recovery
// - code 6 bus/privilege error, 7 pin contention, 5 reserved
// - inter-byte delay enable adds two idle bits between load response bytes
// - parity disable ignores the parity bit and reports no parity errors
// - unless disabled, flag a time-out after 65536 cycles without response
// - response signature disable stops all response signatures
// - guard time on rx-to-tx turn: 128 cycles halving to 2; 7 reserved
// - neg-ack disable suppresses the nack on reset during load or store
// - contention detection runs while its disable bit is zero
// - link disable stops the phy, drops clock request, clears config and keys
// - user row key bit sets on decode; debugger writes it to end session
// - programming key bit sets on decode, clears when programming ready rises
// - erase key bit sets on decode, clears on the issued reset request
// - 0x59 in reset request asserts system reset; 0x00 or any other code releases it
// - a requested system reset leaves the link logic and registers untouched, save the erase key bit
// - registers reachable only through link instructions, not the processor
`ifndef DLK_CFG_SVH
`define DLK_CFG_SVH
// ============================================================
// register offsets
// ============================================================
`define DLK_OFS_REV 4'h0
`define DLK_OFS_ERR 4'h1
`define DLK_OFS_PHY 4'h2
`define DLK_OFS_FEAT 4'h3
`define DLK_OFS_KEY 4'h7
`define DLK_OFS_RESET_REQUEST_CODE 4'h8
// ============================================================
// field positions
// ============================================================
`define DLK_B_INTER_BYTE_DELAY_EN 7
`define DLK_B_PAROFF 5
`define DLK_B_TOOFF 4
`define DLK_B_RSPOFF 3
`define DLK_B_NACKOFF 4
`define DLK_B_CCOFF 3
`define DLK_B_DIS 2
`define DLK_B_UROW 5
`define DLK_B_PROG 4
`define DLK_B_ERASE 3
// ============================================================
// reset values and codes
// ============================================================
`define DLK_CTRL_RST 8'h00
`define DLK_RESET_REQUEST_CODE_RST 8'h00
`define DLK_RST_CODE 8'h59
`define DLK_RUN_CODE 8'h00
// ============================================================
// timing, in link clock cycles or bit periods
// ============================================================
`define DLK_GUARD_MAX 8'h80
`define DLK_GUARD_RSVD 3'h7
`define DLK_GAP_BITS 8'h02
`define DLK_TIMEOUT_CYC 65536
`endif

// ### inc/dlk_pkg.sv
// ============================================================
// debug link register bank types
// ============================================================
// used through dlk_pkg:: names, never imported
package dlk_pkg;
  // error signature codes, 5 left reserved
  typedef enum logic [2:0] {
    DLK_ERR_NONE = 3'h0,
    DLK_ERR_PARITY = 3'h1,
    DLK_ERR_FRAME = 3'h2,
    DLK_ERR_TIMEOUT = 3'h3,
    DLK_ERR_CLKREC = 3'h4,
    DLK_ERR_BUS = 3'h6,
    DLK_ERR_CONTEND = 3'h7
  } dlk_err_t;
  // configuration seen by the phy
  typedef struct packed {
    logic inter_byte_delay_en;
    logic parity_off;
    logic timeout_off;
    logic rsp_off;
    logic [2:0] gt_sel;
    logic nack_off;
    logic cc_off;
  } dlk_cfg_t;
  // error pulses from the phy
  typedef struct packed {
    logic parity;
    logic frame;
    logic clkrec;
    logic bus;
  } dlk_err_evt_t;
  // key decode pulses and key status
  typedef struct packed {
    logic urow;
    logic prog;
    logic erase;
  } dlk_keys_t;
endpackage

// ### design/dlk_delay_timer.sv
// ============================================================
// down-counting delay timer
// ============================================================
// start loads a length; each tick counts one down; busy while nonzero
`timescale 1ns/1ps
module dlk_delay_timer #(
  parameter int W = 8
) (
  input wire logic i_ref_clk, // link clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_start, // load pulse
  input wire logic [W-1:0] i_len, // length in ticks
  input wire logic i_tick, // count enable
  output logic o_busy // delay running
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;

  // restart wins over a running count
  always_comb begin
    cnt_next = cnt_reg;
    if (i_start) begin
      cnt_next = i_len;
    end else if (i_tick && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
    busy_next = (cnt_next != '0);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign o_busy = busy_reg;
endmodule // dlk_delay_timer

// ### design/dlk_timeout_wd.sv
// ============================================================
// access-layer response watchdog
// ============================================================
// armed by a request to the access layer, stopped by its answer
`timescale 1ns/1ps
module dlk_timeout_wd #(
  parameter int CYC = 65536,
  parameter int W = 17
) (
  input wire logic i_ref_clk, // link clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_arm, // request sent
  input wire logic i_done, // response came
  input wire logic i_off, // detection disabled
  output logic o_expire // one-cycle time-out pulse
);
  logic act_reg, act_next;
  logic [W-1:0] cnt_reg, cnt_next;
  logic exp_reg, exp_next;

  // expire exactly CYC cycles after arming
  always_comb begin
    act_next = act_reg;
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (i_off || i_done) begin
      act_next = 1'b0;
    end else if (i_arm) begin
      act_next = 1'b1;
      cnt_next = '0;
    end else if (act_reg) begin
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg == W'(CYC - 1)) begin
        exp_next = 1'b1;
        act_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      act_reg <= 1'b0;
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign o_expire = exp_reg;
endmodule // dlk_timeout_wd

// ### design/dlk_link_regs.sv
// ============================================================
// debug link control and status register bank
// ============================================================
// reached only by link register instructions from the debugger;
// the phy, key decoder and system reset logic sit outside, same clock
`timescale 1ns/1ps
`include "dlk_cfg.svh"
module dlk_link_regs #(
  parameter logic [3:0] LINK_REV = 4'hA, // arbitrary revision value
  parameter int TIMEOUT_CYC = `DLK_TIMEOUT_CYC // response wait limit
) (
  input wire logic i_ref_clk, // link clock, 50 MHz
  input wire logic i_rst, // sync reset, high
  input wire logic i_reg_wr, // register store pulse
  input wire logic i_reg_rd, // register load pulse
  input wire logic [3:0] i_reg_addr, // register offset
  input wire logic [7:0] i_reg_wdata, // store data
  output logic [7:0] o_reg_rdata, // load data
  output logic o_reg_rvalid, // load data valid pulse
  input wire dlk_pkg::dlk_err_evt_t i_err, // phy error pulses
  input wire logic i_acc_req, // request to access layer
  input wire logic i_acc_rsp, // access layer answered
  input wire logic i_turnaround, // rx-to-tx switch pulse
  input wire logic i_tx_byte_done, // load response byte sent
  input wire logic i_bit_tick, // one pulse per bit period
  input wire logic i_ld_st_busy, // load or store in progress
  input wire dlk_pkg::dlk_keys_t i_key_ok, // key decode pulses
  input wire logic i_prog_ready, // system programming-ready flag
  input wire logic i_link_wake, // enable sequence seen on pin
  input wire logic i_pin_in, // link pin level, async
  input wire logic i_pin_drv, // level phy drives
  input wire logic i_pin_oe, // phy drives the pin
  output dlk_pkg::dlk_cfg_t o_cfg, // phy configuration
  output logic o_link_disable, // phy turned off
  output logic o_clk_req, // system clock request
  output logic o_link_rst, // link logic reset pulse
  output logic o_sys_rst, // system reset request
  output logic o_nack_send, // send nack pulse
  output logic o_guard_busy, // guard time running
  output logic o_tx_gap // inter-byte gap running
);
  // ============================================================
  // state
  // ============================================================
  dlk_pkg::dlk_cfg_t cfg_reg, cfg_next;
  logic [2:0] err_reg, err_next;
  dlk_pkg::dlk_keys_t key_reg, key_next;
  logic [7:0] rstq_reg, rstq_next;
  logic dis_reg, dis_next;
  logic clkreq_reg, clkreq_next;
  logic lrst_reg, lrst_next;
  logic sysrst_reg, sysrst_next;
  logic nack_reg, nack_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic prdy_reg;
  logic pin_s1_reg, pin_s2_reg;
  logic drv_d1_reg, drv_d2_reg;
  logic oe_d1_reg, oe_d2_reg;
  logic wr_phy, wr_feat, wr_key, wr_rstq, rd_err;
  logic dis_hit, sysrst_rise, prdy_rise, contend;
  logic wd_expire, guard_busy, gap_busy;
  logic [7:0] guard_len;
  logic [7:0] feat_rd, key_rd;

  // ============================================================
  // access decode
  // ============================================================
  // no processor port exists, so only the link can reach these
  always_comb begin
    wr_phy = i_reg_wr && i_reg_addr == `DLK_OFS_PHY;
    wr_feat = i_reg_wr && i_reg_addr == `DLK_OFS_FEAT;
    wr_key = i_reg_wr && i_reg_addr == `DLK_OFS_KEY;
    wr_rstq = i_reg_wr && i_reg_addr == `DLK_OFS_RESET_REQUEST_CODE;
    rd_err = i_reg_rd && i_reg_addr == `DLK_OFS_ERR;
    dis_hit = wr_feat && i_reg_wdata[`DLK_B_DIS];
  end

  // ============================================================
  // pin sampling for contention
  // ============================================================
  // drive level delayed to line up with the two-stage synchroniser
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      drv_d1_reg <= 1'b1;
      drv_d2_reg <= 1'b1;
      oe_d1_reg <= 1'b0;
      oe_d2_reg <= 1'b0;
      prdy_reg <= 1'b0;
    end else begin
      pin_s1_reg <= i_pin_in;
      pin_s2_reg <= pin_s1_reg;
      drv_d1_reg <= i_pin_drv;
      drv_d2_reg <= drv_d1_reg;
      oe_d1_reg <= i_pin_oe;
      oe_d2_reg <= oe_d1_reg;
      prdy_reg <= i_prog_ready;
    end
  end

  // skipped entirely while the disable bit is one
  assign contend = oe_d2_reg && (pin_s2_reg != drv_d2_reg) && !cfg_reg.cc_off;

  // ============================================================
  // error signature
  // ============================================================
  // same-cycle errors: highest code wins; later errors overwrite older
  always_comb begin
    err_next = err_reg;
    if (rd_err) begin
      err_next = dlk_pkg::DLK_ERR_NONE;
    end
    if (contend) begin
      err_next = dlk_pkg::DLK_ERR_CONTEND;
    end else if (i_err.bus) begin
      err_next = dlk_pkg::DLK_ERR_BUS;
    end else if (i_err.clkrec) begin
      err_next = dlk_pkg::DLK_ERR_CLKREC;
    end else if (wd_expire) begin
      err_next = dlk_pkg::DLK_ERR_TIMEOUT;
    end else if (i_err.frame) begin
      err_next = dlk_pkg::DLK_ERR_FRAME;
    end else if (i_err.parity && !cfg_reg.parity_off) begin
      err_next = dlk_pkg::DLK_ERR_PARITY;
    end
    // the last assignment above holds the newest error
  end

  // ============================================================
  // control registers, keys, reset request
  // ============================================================
  always_comb begin
    cfg_next = cfg_reg;
    dis_next = dis_reg;
    rstq_next = rstq_reg;
    if (wr_phy) begin
      cfg_next.inter_byte_delay_en = i_reg_wdata[`DLK_B_INTER_BYTE_DELAY_EN];
      cfg_next.parity_off = i_reg_wdata[`DLK_B_PAROFF];
      cfg_next.timeout_off = i_reg_wdata[`DLK_B_TOOFF];
      cfg_next.rsp_off = i_reg_wdata[`DLK_B_RSPOFF];
      cfg_next.gt_sel = i_reg_wdata[2:0];
    end
    if (wr_feat) begin
      cfg_next.nack_off = i_reg_wdata[`DLK_B_NACKOFF];
      cfg_next.cc_off = i_reg_wdata[`DLK_B_CCOFF];
    end
    if (wr_rstq) begin
      rstq_next = i_reg_wdata;
    end
    // disabling wipes phy config; only the pin wake sequence re-enables
    if (dis_hit) begin
      cfg_next = dlk_pkg::dlk_cfg_t'(`DLK_CTRL_RST);
      dis_next = 1'b1;
    end else if (i_link_wake) begin
      dis_next = 1'b0;
    end
  end

  // reserved codes store but never assert the system reset
  always_comb begin
    sysrst_next = (rstq_next == `DLK_RST_CODE);
    sysrst_rise = sysrst_next && !sysrst_reg;
    prdy_rise = i_prog_ready && !prdy_reg;
    clkreq_next = !dis_next;
    lrst_next = dis_hit;
    // only a reset issued during a transfer earns a nack
    nack_next = sysrst_rise && i_ld_st_busy && !cfg_reg.nack_off;
  end

  // key bits: a decode in the same cycle as a clear keeps the bit set, except a link disable, which clears all keys
  always_comb begin
    key_next.urow = i_key_ok.urow ||
      (key_reg.urow && !(wr_key && i_reg_wdata[`DLK_B_UROW]));
    key_next.prog = i_key_ok.prog || (key_reg.prog && !prdy_rise);
    key_next.erase = i_key_ok.erase || (key_reg.erase && !sysrst_rise);
    if (dis_hit) begin
      key_next = '0;
    end
  end

  // ============================================================
  // read path
  // ============================================================
  always_comb begin
    feat_rd = 8'h00;
    feat_rd[`DLK_B_NACKOFF] = cfg_reg.nack_off;
    feat_rd[`DLK_B_CCOFF] = cfg_reg.cc_off;
    feat_rd[`DLK_B_DIS] = dis_reg;
    key_rd = 8'h00;
    key_rd[`DLK_B_UROW] = key_reg.urow;
    key_rd[`DLK_B_PROG] = key_reg.prog;
    key_rd[`DLK_B_ERASE] = key_reg.erase;
    rvalid_next = i_reg_rd;
    rdata_next = 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `DLK_OFS_REV: rdata_next = {LINK_REV, 4'h0};
        `DLK_OFS_ERR: rdata_next = {5'h00, err_reg};
        `DLK_OFS_PHY: rdata_next = {cfg_reg.inter_byte_delay_en, 1'b0, cfg_reg.parity_off,
          cfg_reg.timeout_off, cfg_reg.rsp_off, cfg_reg.gt_sel};
        `DLK_OFS_FEAT: rdata_next = feat_rd;
        `DLK_OFS_KEY: rdata_next = key_rd;
        `DLK_OFS_RESET_REQUEST_CODE: rdata_next = rstq_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ============================================================
  // registers
  // ============================================================
  // only i_rst clears this bank; the system reset it drives clears just the erase key
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_reg <= dlk_pkg::dlk_cfg_t'(`DLK_CTRL_RST);
      err_reg <= dlk_pkg::DLK_ERR_NONE;
      key_reg <= '0;
      rstq_reg <= `DLK_RESET_REQUEST_CODE_RST;
      dis_reg <= 1'b0;
      clkreq_reg <= 1'b1;
      lrst_reg <= 1'b0;
      sysrst_reg <= 1'b0;
      nack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      err_reg <= err_next;
      key_reg <= key_next;
      rstq_reg <= rstq_next;
      dis_reg <= dis_next;
      clkreq_reg <= clkreq_next;
      lrst_reg <= lrst_next;
      sysrst_reg <= sysrst_next;
      nack_reg <= nack_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ============================================================
  // timers
  // ============================================================
  // reserved guard setting falls back to the longest guard
  always_comb begin
    if (cfg_reg.gt_sel == `DLK_GUARD_RSVD) begin
      guard_len = `DLK_GUARD_MAX;
    end else begin
      guard_len = `DLK_GUARD_MAX >> cfg_reg.gt_sel;
    end
  end

  dlk_delay_timer #(.W(8)) u_guard (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(i_turnaround),
    .i_len(guard_len),
    .i_tick(1'b1),
    .o_busy(guard_busy)
  );

  // gap counted in bit periods, only when the delay is enabled
  dlk_delay_timer #(.W(8)) u_gap (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(i_tx_byte_done && cfg_reg.inter_byte_delay_en),
    .i_len(`DLK_GAP_BITS),
    .i_tick(i_bit_tick),
    .o_busy(gap_busy)
  );

  dlk_timeout_wd #(.CYC(TIMEOUT_CYC), .W(17)) u_wd (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_arm(i_acc_req),
    .i_done(i_acc_rsp),
    .i_off(cfg_reg.timeout_off),
    .o_expire(wd_expire)
  );

  // ============================================================
  // outputs
  // ============================================================
  assign o_cfg = cfg_reg;
  assign o_link_disable = dis_reg;
  assign o_clk_req = clkreq_reg;
  assign o_link_rst = lrst_reg;
  assign o_sys_rst = sysrst_reg;
  assign o_nack_send = nack_reg;
  assign o_guard_busy = guard_busy;
  assign o_tx_gap = gap_busy;
  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

  // ============================================================
  // checks
  // ============================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd_rev;
    i_reg_rd && i_reg_addr == `DLK_OFS_REV;
  endsequence
  sequence s_quiet_err;
    !contend && !i_err.bus && !i_err.clkrec && !wd_expire && !i_err.frame;
  endsequence
  sequence s_guard2;
    i_turnaround && cfg_reg.gt_sel == 3'h6;
  endsequence

  chk_rev_field: assert property (s_rd_rev |=>
    o_reg_rvalid && o_reg_rdata == {LINK_REV, 4'h0})
    else $error("revision read wrong");
  chk_err_readclr: assert property (rd_err ##0 s_quiet_err ##0 !i_err.parity
    |=> err_reg == 3'h0)
    else $error("error field not cleared by read");
  chk_parity_code: assert property ((i_err.parity && !cfg_reg.parity_off)
    ##0 s_quiet_err |=> err_reg == 3'h1)
    else $error("parity code not loaded");
  chk_parity_off: assert property ((cfg_reg.parity_off && err_reg != 3'h1 &&
    !wr_phy) |=> err_reg != 3'h1)
    else $error("parity reported while disabled");
  chk_cc_off: assert property ((cfg_reg.cc_off && err_reg != 3'h7 && !wr_feat)
    |=> err_reg != 3'h7)
    else $error("contention reported while disabled");
  chk_guard_two: assert property (s_guard2 ##0 !wr_phy |=>
    o_guard_busy [*2] ##1 (!o_guard_busy || $past(i_turnaround)))
    else $error("guard time not two cycles");
  chk_reset_req: assert property ((wr_rstq && i_reg_wdata == `DLK_RST_CODE)
    |=> o_sys_rst ##1 (o_sys_rst || $past(wr_rstq)))
    else $error("system reset not asserted");
  chk_reset_rel: assert property ((wr_rstq && i_reg_wdata == `DLK_RUN_CODE)
    |=> !o_sys_rst)
    else $error("system reset not released");
  chk_disable_all: assert property (dis_hit |=> o_link_disable &&
    o_cfg == dlk_pkg::dlk_cfg_t'(8'h00) && key_reg == '0 && o_link_rst ##1 !o_clk_req)
    else $error("link disable incomplete");
  chk_nack_gate: assert property (o_nack_send |->
    !$past(cfg_reg.nack_off) && $past(i_ld_st_busy) && o_sys_rst)
    else $error("nack sent when not allowed");
  chk_erase_clr: assert property ((key_reg.erase && sysrst_rise && !i_key_ok.erase
    && !dis_hit) |=> !key_reg.erase)
    else $error("erase key not cleared by reset request");
endmodule // dlk_link_regs

// ### verif/dlk_pin_model.sv
// ============================================================
// debugger end of the single-wire link pin
// ============================================================
// the debugger's own pull-up holds the idle line high; a clash
// drives the opposite of what the device drives
`timescale 1ns/1ps
module dlk_pin_model (
  input wire logic i_drv, // level the device drives
  input wire logic i_oe, // device drives the pin
  input wire logic i_clash, // debugger fights the device
  output logic o_pin // resolved pin level
);
  // wire resolution; a released line shows the pull-up, not a stale value
  assign o_pin = i_oe ? (i_drv ^ i_clash) : 1'b1;
endmodule // dlk_pin_model

// ### verif/test_dlk_link_regs.sv
// ============================================================
// self-checking bench of the debug link register bank
// ============================================================
// one 50 MHz link clock; the response time-out is shortened to TO
`timescale 1ns/1ps
module test_dlk_link_regs;
  localparam int TO = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic acc = 1'b0;
  logic turn = 1'b0;
  logic ldst = 1'b0;
  logic prdy = 1'b0;
  logic drv = 1'b0;
  logic oe = 1'b0;
  logic clash = 1'b0;
  logic rsp = 1'b0;
  logic bdone = 1'b0;
  logic btick = 1'b0;
  logic wake = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic pin, rvalid, dis, creq, srst, nack, gbusy, lrst, gap;
  dlk_pkg::dlk_err_evt_t err = '0;
  dlk_pkg::dlk_keys_t key = '0;
  dlk_pkg::dlk_cfg_t cfg;
  int err_total = 0;
  int n_tests = 0;
  // ============================================================
  // clock, far side and device
  // ============================================================
  initial forever #10 clk = ~clk;
  dlk_pin_model pin_u (.i_drv(drv), .i_oe(oe), .i_clash(clash), .o_pin(pin));
  dlk_link_regs #(.LINK_REV(4'h5), .TIMEOUT_CYC(TO)) dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_err(err),
    .i_acc_req(acc), .i_acc_rsp(rsp), .i_turnaround(turn), .i_tx_byte_done(bdone),
    .i_bit_tick(btick), .i_ld_st_busy(ldst), .i_key_ok(key), .i_prog_ready(prdy),
    .i_link_wake(wake), .i_pin_in(pin), .i_pin_drv(drv), .i_pin_oe(oe), .o_cfg(cfg),
    .o_link_disable(dis), .o_clk_req(creq), .o_link_rst(lrst), .o_sys_rst(srst),
    .o_nack_send(nack), .o_guard_busy(gbusy), .o_tx_gap(gap));
  // ============================================================
  // shared tasks
  // ============================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // store: held one edge, released after it
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // load: data counts only while its valid pulse stands
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rvalid ? rdata : 8'hEE, exp);
  endtask
  task automatic pulse(input logic [3:0] e, input logic [2:0] k);
    @(posedge clk);
    err <= e;
    key <= k;
    @(posedge clk);
    err <= '0;
    key <= '0;
    #1;
  endtask
  task automatic test_done;
    $display("Comparisons %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_reset_vals;
    chk({7'h0, creq}, 8'h01);
    rd_chk(4'h0, 8'h50);
    wr_reg(4'h0, 8'hFF);
    rd_chk(4'h0, 8'h50);
    rd_chk(4'h5, 8'h00);
  endtask
  // each phy error pulse in turn; read clears; latest wins; parity can be masked
  task automatic t_err_codes;
    logic [2:0] code [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    for (int i = 0; i < 4; i++) begin
      pulse(4'h8 >> i, 3'h0);
      rd_chk(4'h1, {5'h0, code[i]});
    end
    rd_chk(4'h1, 8'h00);
    pulse(4'h8, 3'h0);
    pulse(4'h1, 3'h0);
    rd_chk(4'h1, 8'h06);
    wr_reg(4'h2, 8'h20);
    pulse(4'h8, 3'h0);
    rd_chk(4'h1, 8'h00);
  endtask
  // no answer, detection off, answer right after the request
  task automatic t_timeout;
    for (int k = 0; k < 3; k++) begin
      wr_reg(4'h2, (k == 1) ? 8'h10 : 8'h00);
      @(posedge clk);
      acc <= 1'b1;
      @(posedge clk);
      acc <= 1'b0;
      rsp <= (k == 2);
      @(posedge clk);
      rsp <= 1'b0;
      repeat (TO + 1) @(posedge clk);
      rd_chk(4'h1, (k == 0) ? 8'h03 : 8'h00);
    end
  endtask
  // guard length for every select code, reserved code taken as longest
  task automatic t_guard;
    int n;
    for (int s = 0; s < 8; s++) begin
      wr_reg(4'h2, 8'(s));
      @(posedge clk);
      turn <= 1'b1;
      @(posedge clk);
      turn <= 1'b0;
      #1;
      n = 0;
      while (gbusy === 1'b1 && n < 300) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(8'(n), s == 7 ? 8'h80 : 8'h80 >> s);
    end
  endtask
  // gap of two bit ticks after a response byte, only with the delay enabled
  task automatic t_gap;
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h2, k ? 8'h08 : 8'h88);
      rd_chk(4'h2, k ? 8'h08 : 8'h88);
      chk({7'h0, cfg.rsp_off}, 8'h01);
      @(posedge clk);
      bdone <= 1'b1;
      @(posedge clk);
      bdone <= 1'b0;
      #1;
      chk({7'h0, gap}, k ? 8'h00 : 8'h01);
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        btick <= 1'b1;
        @(posedge clk);
        btick <= 1'b0;
        #1;
        chk({7'h0, gap}, (k == 0 && j == 0) ? 8'h01 : 8'h00);
      end
    end
  endtask
  task automatic t_contend;
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h3, k ? 8'h08 : 8'h00);
      @(posedge clk);
      oe <= 1'b1;
      drv <= 1'b1;
      clash <= 1'b1;
      repeat (6) @(posedge clk);
      oe <= 1'b0;
      clash <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(4'h1, k ? 8'h00 : 8'h07);
    end
  endtask
  // reset request during a load, with and without the nack masked
  task automatic t_sys_reset;
    logic seen;
    wr_reg(4'h2, 8'h85);
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h3, k ? 8'h10 : 8'h00);
      pulse(4'h0, 3'h1);
      rd_chk(4'h7, 8'h08);
      @(posedge clk);
      ldst <= 1'b1;
      wr_reg(4'h8, 8'h59);
      chk({7'h0, srst}, 8'h01);
      seen = 1'b0;
      repeat (3) begin
        seen = seen | nack;
        @(posedge clk);
        #1;
      end
      chk({7'h0, seen}, k ? 8'h00 : 8'h01);
      @(posedge clk);
      ldst <= 1'b0;
      rd_chk(4'h7, 8'h00);
      rd_chk(4'h2, 8'h85);
      wr_reg(4'h8, 8'h00);
      chk({7'h0, srst}, 8'h00);
    end
    wr_reg(4'h8, 8'h12);
    chk({7'h0, srst}, 8'h00);
  endtask
  task automatic t_keys;
    prdy <= 1'b0;
    pulse(4'h0, 3'h6);
    rd_chk(4'h7, 8'h30);
    wr_reg(4'h7, 8'h20);
    @(posedge clk);
    prdy <= 1'b1;
    rd_chk(4'h7, 8'h00);
  endtask
  task automatic t_disable;
    pulse(4'h0, 3'h7);
    wr_reg(4'h3, 8'h04);
    chk({5'h0, lrst, dis, creq}, 8'h06);
    chk({7'h0, |cfg}, 8'h00);
    rd_chk(4'h7, 8'h00);
    chk({7'h0, lrst}, 8'h00);
    // wake sequence brings the link and its clock request back
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1;
    chk({6'h0, dis, creq}, 8'h01);
  endtask
  // ============================================================
  // main sequence and hang guard
  // ============================================================
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals;
    t_err_codes;
    t_timeout;
    t_guard;
    t_gap;
    t_contend;
    t_sys_reset;
    t_keys;
    t_disable;
    test_done;
  end
  initial begin
    #1000000;
    err_total++;
    test_done;
  end
endmodule // test_dlk_link_regs
